/* File: core/tpc_regs.sv */
// What this block does
// - divider register: width-generator select upper nibble, multi-pulse select lower nibble
// - width-generator divider divides clock by two to the select, 1 up to 128
// - multi-pulse divider uses the same power-of-two encoding, 1 up to 128
// - channel 0 charge current select: 10 uA steps, 10 uA to 320 uA
`timescale 1ns/10ps
`default_nettype none
module tpc_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// host register port
	input wire tpc_pkg::tpc_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic hit,
	// configuration outputs
	output var tpc_pkg::tpc_cfg_t cfg,
	output logic [8:0] charge_current_ua_ch0,
	// divided generator ticks
	output logic width_tick,
	output logic multi_tick
);
	typedef struct packed {
		logic [7:0] pd_range;
		logic [7:0] charge;
		logic [7:0] clk_div;
		logic [7:0] width_upper;
		logic [7:0] width_ch2;
		logic [7:0] width_ch1;
		logic [7:0] width_ch0;
		logic [7:0] off_upper;
		logic [7:0] off_ch2;
		logic [7:0] off_ch1;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
		logic [8:0] charge_ua;
	} tpc_reg_state_t;

	tpc_reg_state_t st;
	tpc_reg_state_t next_st;
	logic width_tick_w;
	logic multi_tick_w;

	// address decode shared by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		return (a >= tpc_pkg::OFS_PD_RANGE_CH0) && (a <= tpc_pkg::OFS_OFF_CH1);
	endfunction

	// current in microamps for a 5-bit select
	function automatic logic [8:0] charge_ua(input logic [4:0] s);
		return 9'((int'(s) + 1) * tpc_pkg::CHARGE_STEP_UA);
	endfunction

	// write, readback and decode; reserved bits store and read as zero
	always_comb
	begin
		next_st = st;
		next_st.rvalid = req.rd;
		next_st.hit = is_mapped(req.addr) && (req.rd || req.wr);
		if (req.wr)
		begin
			case (req.addr)
				tpc_pkg::OFS_PD_RANGE_CH0: next_st.pd_range = {3'h0, req.wdata[4:0]};
				tpc_pkg::OFS_CHARGE_CH0: next_st.charge = {3'h0, req.wdata[4:0]};
				tpc_pkg::OFS_CLK_DIV: next_st.clk_div = req.wdata;
				tpc_pkg::OFS_WIDTH_UPPER: next_st.width_upper = {2'h0, req.wdata[5:0]};
				tpc_pkg::OFS_WIDTH_CH2: next_st.width_ch2 = req.wdata;
				tpc_pkg::OFS_WIDTH_CH1: next_st.width_ch1 = req.wdata;
				tpc_pkg::OFS_WIDTH_CH0: next_st.width_ch0 = req.wdata;
				tpc_pkg::OFS_OFF_UPPER: next_st.off_upper = {2'h0, req.wdata[5:0]};
				tpc_pkg::OFS_OFF_CH2: next_st.off_ch2 = req.wdata;
				tpc_pkg::OFS_OFF_CH1: next_st.off_ch1 = req.wdata;
				default: ;
			endcase
		end
		next_st.rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				tpc_pkg::OFS_PD_RANGE_CH0: next_st.rdata = st.pd_range;
				tpc_pkg::OFS_CHARGE_CH0: next_st.rdata = st.charge;
				tpc_pkg::OFS_CLK_DIV: next_st.rdata = st.clk_div;
				tpc_pkg::OFS_WIDTH_UPPER: next_st.rdata = st.width_upper;
				tpc_pkg::OFS_WIDTH_CH2: next_st.rdata = st.width_ch2;
				tpc_pkg::OFS_WIDTH_CH1: next_st.rdata = st.width_ch1;
				tpc_pkg::OFS_WIDTH_CH0: next_st.rdata = st.width_ch0;
				tpc_pkg::OFS_OFF_UPPER: next_st.rdata = st.off_upper;
				tpc_pkg::OFS_OFF_CH2: next_st.rdata = st.off_ch2;
				tpc_pkg::OFS_OFF_CH1: next_st.rdata = st.off_ch1;
				default: next_st.rdata = 8'h00; // unmapped reads as zero
			endcase
		end
		// registered from the next value so the current changes on the same edge as the charge register
		next_st.charge_ua = charge_ua(next_st.charge[4:0]);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '0;
			st.charge_ua <= 9'(tpc_pkg::CHARGE_STEP_UA);
		end
		else
			st <= next_st;
	end

	// nibble split of the divider register
	tpc_divider #(.CNT_BITS(7)) u_width_div (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.sel(st.clk_div[tpc_pkg::DIV_WIDTH_LSB +: tpc_pkg::DIV_SEL_BITS]),
		.tick(width_tick_w)
	);

	tpc_divider #(.CNT_BITS(7)) u_multi_div (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.sel(st.clk_div[tpc_pkg::DIV_MULTI_LSB +: tpc_pkg::DIV_SEL_BITS]),
		.tick(multi_tick_w)
	);

	// outputs all come from flip-flops
	assign rdata = st.rdata;
	assign rvalid = st.rvalid;
	assign hit = st.hit;
	assign charge_current_ua_ch0 = st.charge_ua;
	assign width_tick = width_tick_w;
	assign multi_tick = multi_tick_w;
	assign cfg.charge_current_sel_ch0 = st.charge[4:0];
	assign cfg.photodetector_range_sel_ch0 = st.pd_range[4:0];
	assign cfg.width_div_sel = st.clk_div[7:4];
	assign cfg.multi_div_sel = st.clk_div[3:0];
	assign cfg.width_on_count_ch0 = {st.width_upper[1:0], st.width_ch0};
	assign cfg.width_on_count_ch1 = {st.width_upper[3:2], st.width_ch1};
	assign cfg.width_on_count_ch2 = {st.width_upper[5:4], st.width_ch2};
	assign cfg.multi_pulse_off_count_ch1 = {st.off_upper[3:2], st.off_ch1};
	assign cfg.multi_pulse_off_count_ch2 = {st.off_upper[5:4], st.off_ch2};
	assign cfg.multi_pulse_off_count_ch0_upper = st.off_upper[1:0];
endmodule
`default_nettype wire

/* File: common/tpc_pkg.sv */
package tpc_pkg;
	// register offsets on the 8-bit host address
	localparam logic [7:0] OFS_PD_RANGE_CH0 = 8'h52;
	localparam logic [7:0] OFS_CHARGE_CH0 = 8'h53;
	localparam logic [7:0] OFS_CLK_DIV = 8'h54;
	localparam logic [7:0] OFS_WIDTH_UPPER = 8'h55;
	localparam logic [7:0] OFS_WIDTH_CH2 = 8'h56;
	localparam logic [7:0] OFS_WIDTH_CH1 = 8'h57;
	localparam logic [7:0] OFS_WIDTH_CH0 = 8'h58;
	localparam logic [7:0] OFS_OFF_UPPER = 8'h59;
	localparam logic [7:0] OFS_OFF_CH2 = 8'h5a;
	localparam logic [7:0] OFS_OFF_CH1 = 8'h5b;
	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// field positions in the divider register
	localparam int DIV_WIDTH_LSB = 4;
	localparam int DIV_MULTI_LSB = 0;
	localparam int SEL_BITS = 5;
	localparam int DIV_SEL_BITS = 4;
	localparam logic [3:0] DIV_SEL_MAX = 4'h7;
	// charge current step in microamps
	localparam int CHARGE_STEP_UA = 10;

	// host register access, one byte per request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tpc_req_t;

	// decoded configuration handed to the analog and timer sections
	typedef struct packed {
		logic [4:0] charge_current_sel_ch0;
		logic [4:0] photodetector_range_sel_ch0;
		logic [3:0] width_div_sel;
		logic [3:0] multi_div_sel;
		logic [9:0] width_on_count_ch0;
		logic [9:0] width_on_count_ch1;
		logic [9:0] width_on_count_ch2;
		logic [9:0] multi_pulse_off_count_ch1;
		logic [9:0] multi_pulse_off_count_ch2;
		logic [1:0] multi_pulse_off_count_ch0_upper;
	} tpc_cfg_t;
endpackage

/* File: core/tpc_divider.sv */
`timescale 1ns/10ps
`default_nettype none
// power-of-two clock-enable divider: one tick every 2**sel clocks, sel above 7 treated as 7
module tpc_divider #(
	parameter int CNT_BITS = 7
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// control
	input wire logic [3:0] sel,
	// divided tick
	output logic tick
);
	// the slowest rate needs a full 7-bit count, refuse anything shorter
	if (CNT_BITS < 7)
	begin : g_cnt_check
		$error("tpc_divider needs at least 7 counter bits for divide-by-128");
	end

	typedef struct packed {
		logic [CNT_BITS-1:0] cnt;
		logic tick;
	} tpc_div_state_t;

	tpc_div_state_t st;
	tpc_div_state_t next_st;
	logic [CNT_BITS-1:0] mask;

	// codes above 0111 are clamped to divide-by-128
	always_comb
	begin
		next_st = st;
		mask = '0;
		for (int i = 0; i < CNT_BITS; i++)
			if (i < int'((sel > tpc_pkg::DIV_SEL_MAX) ? tpc_pkg::DIV_SEL_MAX : sel))
				mask[i] = 1'b1;
		next_st.tick = ((st.cnt & mask) == mask);
		next_st.cnt = (next_st.tick) ? '0 : CNT_BITS'(st.cnt + 1'b1);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;
endmodule
`default_nettype wire

/* File: sim/tpc_regs_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module tpc_regs_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// host request
	input wire tpc_pkg::tpc_req_t req,
	// configuration and ticks
	input wire tpc_pkg::tpc_cfg_t cfg,
	input wire logic [8:0] charge_current_ua_ch0,
	input wire logic width_tick,
	input wire logic multi_tick
);
	logic [7:0] wgap;
	logic [7:0] mgap;
	// codes above 7 clamp to the slowest rate
	wire [7:0] wper = cfg.width_div_sel[3] ? 8'h80 : 8'h01 << cfg.width_div_sel[2:0];
	wire [7:0] mper = cfg.multi_div_sel[3] ? 8'h80 : 8'h01 << cfg.multi_div_sel[2:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// clocks since last tick; zero while the phase is unknown after a select change
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wgap <= 8'h00;
			mgap <= 8'h00;
		end
		else
		begin
			wgap <= $changed(cfg.width_div_sel) ? 8'h00 : width_tick ? 8'h01 : wgap + 8'(wgap != 0);
			mgap <= $changed(cfg.multi_div_sel) ? 8'h00 : multi_tick ? 8'h01 : mgap + 8'(mgap != 0);
		end
	end
	div_fields_a: assert property (req.wr && req.addr == 8'h54 |=>
		{cfg.width_div_sel, cfg.multi_div_sel} == $past(req.wdata)) else $error("div fields");
	width_rate_a: assert property (wgap != 0 && $stable(cfg.width_div_sel) |->
		width_tick == (wgap == wper)) else $error("width tick spacing");
	multi_rate_a: assert property (mgap != 0 && $stable(cfg.multi_div_sel) |->
		multi_tick == (mgap == mper)) else $error("multi tick spacing");
	charge_ua_a: assert property (1'b1 |->
		charge_current_ua_ch0 == 9'(cfg.charge_current_sel_ch0) * 9'h00a + 9'h00a)
		else $error("charge current");
	cover property (req.wr && req.addr == 8'h54);
	cover property (width_tick && cfg.width_div_sel == 4'h7);
	cover property (charge_current_ua_ch0 == 9'h140);
endmodule
bind tpc_regs tpc_regs_chk tpc_regs_chk_inst (.ref_clk, .nrst, .req, .cfg,
	.charge_current_ua_ch0, .width_tick, .multi_tick);
`default_nettype wire

/* File: sim/tpc_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tpc_regs_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	tpc_pkg::tpc_req_t req = '0;
	logic [7:0] rdata;
	logic rvalid, hit, width_tick, multi_tick;
	tpc_pkg::tpc_cfg_t cfg;
	logic [8:0] ua;
	int bad_count = 0, checks = 0, nw, nm;
	always #5 ref_clk = ~ref_clk;
	tpc_regs tpc_regs_inst (.ref_clk, .nrst, .req, .rdata, .rvalid, .hit, .cfg,
		.charge_current_ua_ch0(ua), .width_tick, .multi_tick);
	// one-cycle write; the pause lets the register edge land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) req <= {1'b1, 1'b0, a, d};
		@(posedge ref_clk) req <= '0;
		#1;
	endtask
	// one-cycle read, answer due one edge later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk) req <= '0;
		#1 `CHK({rvalid, hit, rdata}, {1'b1, (a >= tpc_pkg::OFS_PD_RANGE_CH0 && a <= tpc_pkg::OFS_OFF_CH1), e})
	endtask
	// ticks over 128 clocks, a multiple of every period
	task automatic count();
		nw = 0;
		nm = 0;
		repeat (128)
		begin
			@(negedge ref_clk);
			nw += int'(width_tick);
			nm += int'(multi_tick);
		end
	endtask
	function automatic int per(int x);
		return 128 >> (x > 7 ? 7 : x);
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// the run needs about 1300 clocks
	initial
	begin
		#100000;
		bad_count++;
		results();
	end
	initial
	begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		// 0x5c lies outside the bank and reads zero
		for (int a = 8'h52; a <= 8'h5c; a++)
			rd(8'(a), 8'h00);
		$display("reset values done");
		for (int k = 0; k < 9; k++)
		begin
			wr(8'h54, 8'(k * 16 + 8 - k));
			rd(8'h54, 8'(k * 16 + 8 - k));
			count();
			`CHK(nw, per(k))
			`CHK(nm, per(8 - k))
		end
		$display("divider codes done");
		for (int c = 0; c < 32; c++)
		begin
			wr(8'h53, 8'(c));
			`CHK(ua, 9'((c + 1) * 10))
		end
		rd(8'h53, 8'h1f);
		wr(8'h53, 8'he0);
		`CHK(ua, 9'h00a)
		$display("charge current done");
		// count registers: upper bits split per channel, reserved bits read zero
		wr(8'h55, 8'hf9);
		wr(8'h58, 8'h12);
		wr(8'h57, 8'h34);
		wr(8'h56, 8'h56);
		wr(8'h59, 8'hc6);
		wr(8'h5b, 8'h9a);
		wr(8'h5a, 8'hbc);
		wr(8'h52, 8'hff);
		wr(8'h5c, 8'hff);
		rd(8'h55, 8'h39);
		rd(8'h59, 8'h06);
		rd(8'h52, 8'h1f);
		rd(8'h5c, 8'h00);
		`CHK(cfg.width_on_count_ch0, 10'h112)
		`CHK(cfg.width_on_count_ch1, 10'h234)
		`CHK(cfg.width_on_count_ch2, 10'h356)
		`CHK(cfg.multi_pulse_off_count_ch1, 10'h19a)
		`CHK(cfg.multi_pulse_off_count_ch2, 10'h0bc)
		`CHK(cfg.multi_pulse_off_count_ch0_upper, 2'h2)
		`CHK(cfg.photodetector_range_sel_ch0, 5'h1f)
		$display("count registers done");
		results();
	end
endmodule
`default_nettype wire
